/* supply_fail_defs.svh */
`ifndef SUPPLY_FAIL_DEFS_SVH
`define SUPPLY_FAIL_DEFS_SVH

// interrupt entry for the early power-fail warning
`define WARN_VECTOR 8'h2B
// number of decoded byte-wide chip enables
`define CE_COUNT 2
// reset values of the pin-facing outputs
`define CE_IDLE 1'b1
`define WR_IDLE 1'b1
`define BACKUP_IDLE 1'b1
// synchroniser depth
`define SYNC_STAGES 2

`endif

/* supply_fail_pkg.sv */
package supply_fail_pkg;
    typedef enum logic [1:0] {
        RUN,
        HOLD_RESET,
        BACKUP
    } power_state_type;
endpackage

/* level_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for asynchronous levels; first stage read only by second
module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // metastability guard stages
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= INIT;
            sync_o <= INIT;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* supply_fail_sequencer.sv */
// Functional notes
// - below warning level with warning enabled, vector processor to entry 2Bh
// - between warning and minimum level, processor keeps running normally
// - at minimum level, hold processor in reset until supply recovers
// - in low-supply reset, all chip enables and write strobe held at 1
// - in low-supply reset, drive supply reset pin to 0
// - below battery switch level, run from backup cell, backup flag low
// - supply reset pin is open-drain input too; external low forces reset
`include "supply_fail_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module supply_fail_sequencer
    import supply_fail_pkg::*;
#(
    parameter int CE_COUNT = `CE_COUNT
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    // comparator levels, high while supply is below that threshold
    input wire logic warning_threshold_i,
    input wire logic min_operating_threshold_i,
    input wire logic battery_switch_threshold_i,
    // core-side controls
    input wire logic warn_enable_i,
    input wire logic warn_ack_i,
    input wire logic [CE_COUNT-1:0] core_ce_n_i,
    input wire logic core_wr_n_i,
    // open-drain supply reset pin
    input wire logic supply_reset_io_n_i,
    output logic supply_reset_io_n_o,
    output logic supply_reset_io_n_oe_o,
    // core-side results, then pin-facing bus strobes, backup flag and power state
    output logic warn_irq_o,
    output logic [7:0] warn_vector_o,
    output logic core_reset_o,
    output logic [CE_COUNT-1:0] bus_ce_n_o,
    output logic bus_wr_n_o,
    output logic backup_active_n_o,
    output supply_fail_pkg::power_state_type state_o
);
    import supply_fail_pkg::*;

    // retimed comparator and pin levels, then internal state
    logic warn_s;
    logic min_s;
    logic batt_s;
    logic ext_rst_n_s;
    logic warn_prev_q;
    logic warn_pend_q;
    logic in_reset;
    power_state_type state_q;
    power_state_type state_d;

    // comparators are analog, so retime before use
    level_sync #(
        .WIDTH(3),
        .INIT(3'h0)
    ) u_cmp_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i({warning_threshold_i, min_operating_threshold_i, battery_switch_threshold_i}),
        .sync_o({warn_s, min_s, batt_s})
    );

    // the pin is wired-and with other parts, so it is asynchronous too
    level_sync #(
        .WIDTH(1),
        .INIT(1'h1)
    ) u_pin_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i(supply_reset_io_n_i),
        .sync_o(ext_rst_n_s)
    );

    // either low band counts as low supply; shared by reset and pin drive
    function automatic logic supply_low(input logic below_min, input logic below_batt);
        return below_min || below_batt;
    endfunction

    // reset holds while supply is low or a neighbour pulls the pin
    assign in_reset = supply_low(min_s, batt_s) || !ext_rst_n_s;

    // next power state; battery level is lowest so it is checked first
    // every low band holds reset, so the core stays quiet on the way down
    always_comb
    begin
        state_d = RUN;
        if (batt_s)
        begin
            state_d = BACKUP;
        end
        else if (in_reset)
        begin
            state_d = HOLD_RESET;
        end
    end

    // state output taken straight from the power state flop
    assign state_o = state_q;

    // power state register
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= RUN;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // warning edge memory
    // reset level matches the comparator idle level, so no false edge
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            warn_prev_q <= 1'b0;
        end
        else
        begin
            warn_prev_q <= warn_s;
        end
    end

    // pending warning: new falling-supply edge wins over acknowledge
    // an ack landing with a fresh edge must not lose that fresh request
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            warn_pend_q <= 1'b0;
        end
        else if (in_reset)
        begin
            warn_pend_q <= 1'b0; // reset state discards any pending request
        end
        else if (warn_s && !warn_prev_q && warn_enable_i)
        begin
            warn_pend_q <= 1'b1;
        end
        else if (warn_ack_i)
        begin
            warn_pend_q <= 1'b0;
        end
    end

    // registered core outputs; execution never halts in the warning band
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            warn_irq_o <= 1'b0;
            warn_vector_o <= `WARN_VECTOR;
            core_reset_o <= 1'b0;
        end
        else
        begin
            warn_irq_o <= warn_pend_q && !in_reset;
            warn_vector_o <= `WARN_VECTOR;
            core_reset_o <= in_reset;
        end
    end

    // bus strobes parked inactive while in reset, else pass through
    // parking costs the core strobes one cycle of latency
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus_ce_n_o <= {CE_COUNT{`CE_IDLE}};
            bus_wr_n_o <= `WR_IDLE;
        end
        else if (in_reset)
        begin
            bus_ce_n_o <= {CE_COUNT{`CE_IDLE}};
            bus_wr_n_o <= `WR_IDLE;
        end
        else
        begin
            bus_ce_n_o <= core_ce_n_i;
            bus_wr_n_o <= core_wr_n_i;
        end
    end

    // open-drain: only low supply drives the pin, never an external pull
    // so two parts cannot latch each other in reset forever
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            supply_reset_io_n_o <= 1'b0;
            supply_reset_io_n_oe_o <= 1'b0;
        end
        else
        begin
            supply_reset_io_n_o <= 1'b0;
            supply_reset_io_n_oe_o <= supply_low(min_s, batt_s);
        end
    end

    // backup indication, low while on the backup cell
    // registered so the flag cannot glitch while the cell takes over
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            backup_active_n_o <= `BACKUP_IDLE;
        end
        else
        begin
            backup_active_n_o <= !batt_s;
        end
    end
endmodule
`default_nettype wire

/* supply_fail_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// pin-level checks; a level is trusted after 5 samples, past the synchroniser
module supply_fail_monitor #(
    parameter int CE_COUNT = 2
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic min_operating_threshold_i,
    input wire logic battery_switch_threshold_i,
    input wire logic supply_reset_io_n_i,
    input wire logic supply_reset_io_n_o,
    input wire logic supply_reset_io_n_oe_o,
    input wire logic warn_irq_o,
    input wire logic [7:0] warn_vector_o,
    input wire logic core_reset_o,
    input wire logic [CE_COUNT-1:0] bus_ce_n_o,
    input wire logic bus_wr_n_o,
    input wire logic backup_active_n_o
);
    // short aliases of the raw levels
    wire logic mn = min_operating_threshold_i;
    wire logic bt = battery_switch_threshold_i;
    wire logic pn = supply_reset_io_n_i;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_IRQ: assert property (warn_irq_o |-> !core_reset_o && warn_vector_o == 8'h2B)
        else $error("irq");
    AST_RUN: assert property ((!mn && !bt && pn) [*5] |-> !core_reset_o)
        else $error("run");
    AST_HOLD: assert property (mn [*5] |-> core_reset_o)
        else $error("hold");
    AST_BUS: assert property (mn [*5] |-> &bus_ce_n_o && bus_wr_n_o)
        else $error("bus");
    AST_PIN: assert property (mn [*5] |-> supply_reset_io_n_oe_o && !supply_reset_io_n_o)
        else $error("pin");
    AST_BAK: assert property (bt [*5] |-> !backup_active_n_o)
        else $error("bak");
    AST_EXT: assert property (!pn [*5] |-> core_reset_o)
        else $error("ext");
    AST_SYNC: assert property ($rose(core_reset_o) |-> $past(mn, 2) || $past(bt, 2) || !$past(pn, 2))
        else $error("sync");
    // main scenarios reached
    cover property ($rose(warn_irq_o));
    cover property ($rose(core_reset_o));
    cover property ($fell(backup_active_n_o));
endmodule
bind supply_fail_sequencer supply_fail_monitor #(.CE_COUNT(CE_COUNT)) mon_u (.*);
`default_nettype wire

/* supply_model.sv */
`timescale 1ns/100ps
`default_nettype none
// supply comparators plus the pulled-up reset wire
module supply_model #(parameter int WARN_MV = 4370, MIN_MV = 4120, BAT_MV = 3000)
(
    input wire logic [15:0] mv_i,
    input wire logic pull_i,
    input wire logic oe_i,
    input wire logic po_i,
    output logic warn_o,
    output logic min_o,
    output logic bat_o,
    output logic pin_n_o
);
    // high while supply is below each trip point
    assign warn_o = mv_i < 16'(WARN_MV);
    assign min_o = mv_i < 16'(MIN_MV);
    assign bat_o = mv_i < 16'(BAT_MV);
    // any party pulling low wins over the pull-up
    assign pin_n_o = !pull_i && (!oe_i || po_i);
endmodule
`default_nettype wire

/* tb_supply_fail_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_supply_fail_sequencer;
    import supply_fail_pkg::*;
    logic clock_i = 0, rst_n_i = 0, warn_enable_i = 1, warn_ack_i = 0, core_wr_n_i = 0;
    logic [1:0] core_ce_n_i = 2'h1;
    logic [15:0] mv = 16'h1130;
    logic pull = 0;
    logic warning_threshold_i, min_operating_threshold_i, battery_switch_threshold_i;
    logic supply_reset_io_n_i, supply_reset_io_n_o, supply_reset_io_n_oe_o, warn_irq_o;
    logic core_reset_o, bus_wr_n_o, backup_active_n_o;
    logic [7:0] warn_vector_o;
    logic [1:0] bus_ce_n_o;
    power_state_type state_o;
    int fail_count = 0, checked = 0;
    // 100 ns clock
    initial
    begin
        forever #50 clock_i = ~clock_i;
    end
    supply_fail_sequencer dut_u (.*);
    supply_model sup_u (.mv_i(mv), .pull_i(pull), .oe_i(supply_reset_io_n_oe_o),
        .po_i(supply_reset_io_n_o), .warn_o(warning_threshold_i),
        .min_o(min_operating_threshold_i), .bat_o(battery_switch_threshold_i),
        .pin_n_o(supply_reset_io_n_i));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // inputs move 10 ns after the edge
    task automatic cyc(int n);
        repeat (n) @(posedge clock_i);
        #10;
    endtask
    task automatic summarize();
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_warn();
        mv = 16'h1068;
        cyc(6);
        chk("irq", 8'h01, 8'(warn_irq_o));
        chk("vec", 8'h2B, warn_vector_o);
        chk("bus", 8'h02, 8'({core_reset_o, bus_ce_n_o, bus_wr_n_o}));
        chk("state", 8'(RUN), 8'(state_o));
        warn_ack_i = 1;
        cyc(3);
        chk("ack", 8'h00, 8'(warn_irq_o));
        warn_ack_i = 0;
    endtask
    // core keeps write and chip enable 1 active, so forcing shows
    task automatic t_min();
        mv = 16'h0FA0;
        cyc(2);
        chk("sync", 8'h00, 8'(core_reset_o));
        cyc(1);
        chk("lat", 8'h01, 8'(core_reset_o));
        cyc(3);
        chk("bus", 8'h0F, 8'({core_reset_o, bus_ce_n_o, bus_wr_n_o}));
        chk("pin", 8'h04, 8'({supply_reset_io_n_oe_o, supply_reset_io_n_o, supply_reset_io_n_i}));
        chk("state", 8'(HOLD_RESET), 8'(state_o));
        mv = 16'h07D0;
        cyc(6);
        chk("bak", 8'h00, 8'(backup_active_n_o));
        chk("state", 8'(BACKUP), 8'(state_o));
        mv = 16'h1130;
        cyc(8);
        chk("up", 8'h12, 8'({backup_active_n_o, core_reset_o, bus_ce_n_o, bus_wr_n_o}));
        chk("state", 8'(RUN), 8'(state_o));
    endtask
    task automatic t_ext();
        pull = 1;
        cyc(5);
        chk("ext", 8'h01, 8'({supply_reset_io_n_oe_o, core_reset_o}));
        chk("state", 8'(HOLD_RESET), 8'(state_o));
        pull = 0;
    endtask
    // warning edge with the interrupt disabled is refused
    task automatic t_nowarn();
        warn_enable_i = 0;
        mv = 16'h1068;
        cyc(6);
        chk("noirq", 8'h00, 8'(warn_irq_o));
        chk("state", 8'(RUN), 8'(state_o));
        mv = 16'h1130;
        warn_enable_i = 1;
        cyc(4);
    endtask
    // reset in mid-run, idle outputs while held, core strobes pass again after release
    task automatic t_reset();
        rst_n_i = 0;
        cyc(1);
        chk("rst", 8'h0F, 8'({bus_ce_n_o, bus_wr_n_o, backup_active_n_o}));
        chk("rst2", 8'h00, 8'({warn_irq_o, core_reset_o, supply_reset_io_n_oe_o}));
        chk("rvec", 8'h2B, warn_vector_o);
        chk("rstate", 8'(RUN), 8'(state_o));
        rst_n_i = 1;
        cyc(2);
        chk("rel", 8'h05, 8'({bus_ce_n_o, bus_wr_n_o, backup_active_n_o}));
        chk("rel2", 8'h00, 8'({warn_irq_o, core_reset_o, supply_reset_io_n_oe_o}));
    endtask
    // main sequence
    initial
    begin
        repeat (10) @(posedge clock_i);
        #10 rst_n_i = 1;
        cyc(2);
        t_nowarn();
        t_warn();
        t_min();
        t_ext();
        t_reset();
        summarize();
    end
    // hang guard, far past the 59-cycle run
    initial
    begin
        #200000;
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire
